// file: rtl/conv_ctrl.sv
`timescale 1ns/1ns
`include "conv_ctrl_regs.svh"

// How it works
// [RULE1] Answer only own address and pin levels
// [RULE2] First byte is address, last bit direction
// [RULE3] First written data byte loads control
// [RULE4] Upper nibble output/config, lower selects channel
// [RULE5] Control bits: 6 out, 5:4 cfg, 2 inc
// [RULE6] Auto-increment channel after every conversion
// [RULE7] Out-of-range channel clamps; increment wraps
// [RULE8] Master writes reserved nibble MSBs as zero
// [RULE9] Reset clears control, converter, oscillator, output
// [RULE10] Later written bytes load output value
// [RULE11] Output buffer on only with enable set
// [RULE12] Hold analogue output during conversion
// [RULE13] Read ack trailing edge starts conversion
// [RULE14] Binary code, two's complement when differential
// [RULE15] Read returns previous conversion result
// [RULE16] First read after reset returns 80h
// [RULE17] Select pin low drives oscillator pin
// [RULE18] Write ends by stop or new start
// [RULE19] Data stable while clock high
// [RULE20] Start and stop detected on data edges
// [RULE21] Eight bits plus acknowledge, unlimited bytes
// [RULE22] Acknowledge every received byte, held low
// [RULE23] Release data after master not-acknowledge
module conv_ctrl
   import conv_ctrl_pkg::*;
#(
   parameter logic [3:0] ADDR_TYPE = `ADDR_TYPE_DEF
) (
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   input  wire logic       conv_clk_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       addr_select_pin_0_in,
   input  wire logic       addr_select_pin_1_in,
   input  wire logic       addr_select_pin_2_in,
   input  wire logic       clock_source_select_pin_in,
   input  wire logic       comparator_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            osc_enable_out,
   output logic            osc_pin_oe_out,
   output logic            outbuf_enable_out,
   output logic [7:0]      dac_value_out,
   output logic [7:0]      sar_code_out,
   output logic            track_hold_out,
   output logic            adc_sample_out,
   output logic [1:0]      mux_channel_out,
   output logic [1:0]      input_config_out,
   output logic            differential_out
);

   link_state_t lq, ld;
   sar_state_t  cq, cd;
   logic [1:0]  rst_sync_q;
   logic [1:0]  conv_rst_sync_q;
   logic        rst_n;
   logic        conv_rst_n;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_evt;
   logic        stop_evt;
   logic        done_evt;
   logic        addr_match;
   logic        wr_ctrl;
   logic        load_rd;
   logic [7:0]  rd_value;

   function automatic logic [1:0] max_chan(input logic [1:0] cfg);
      unique case (cfg)
         2'h0:    max_chan = 2'h3;
         2'h1:    max_chan = 2'h2;
         2'h2:    max_chan = 2'h2;
         2'h3:    max_chan = 2'h1;
      endcase
   endfunction

   function automatic logic [1:0] clamp_chan(input logic [1:0] ch,
                                             input logic [1:0] cfg);
      clamp_chan = (ch > max_chan(cfg)) ? max_chan(cfg) : ch;
   endfunction

   function automatic logic [1:0] next_chan(input logic [1:0] ch,
                                            input logic [1:0] cfg);
      next_chan = (ch >= max_chan(cfg)) ? 2'h0 : 2'(ch + 2'h1);
   endfunction

   function automatic logic is_diff(input logic [1:0] ch,
                                    input logic [1:0] cfg);
      unique case (cfg)
         2'h0:    is_diff = 1'b0;
         2'h2:    is_diff = (ch == 2'h2);
         default: is_diff = 1'b1;
      endcase
   endfunction

   // Reset release, one chain per clock
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge conv_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         conv_rst_sync_q <= 2'h0;
      end else begin
         conv_rst_sync_q <= {conv_rst_sync_q[0], 1'b1};
      end
   end
   assign conv_rst_n = conv_rst_sync_q[1];

   // Bus events, from synchronised copies only
   assign scl_rise  = lq.scl_s & ~lq.scl_p;
   assign scl_fall  = ~lq.scl_s & lq.scl_p;
   assign start_evt = lq.scl_s & lq.scl_p & ~lq.sda_s & lq.sda_p; // [RULE20]
   assign stop_evt  = lq.scl_s & lq.scl_p & lq.sda_s & ~lq.sda_p;  // [RULE20]
   assign done_evt  = lq.done_s != lq.done_p;
   assign addr_match = (lq.shift[7:4] == ADDR_TYPE) &&
                       (lq.shift[3:1] == lq.addr_s); // [RULE1]
   // Result landing this very cycle is newer than the stored one
   assign rd_value  = done_evt ? cq.result : lq.adc; // [RULE15]

   always_comb begin
      ld = lq;
      wr_ctrl = 1'b0;
      load_rd = 1'b0;
      ld.scl_m  = scl_in;
      ld.scl_s  = lq.scl_m;
      ld.scl_p  = lq.scl_s;
      ld.sda_m  = sda_in;
      ld.sda_s  = lq.sda_m;
      ld.sda_p  = lq.sda_s;
      ld.addr_m = {addr_select_pin_2_in, addr_select_pin_1_in,
                   addr_select_pin_0_in};
      ld.addr_s = lq.addr_m;
      ld.srcsel_m = clock_source_select_pin_in;
      ld.srcsel_s = lq.srcsel_m;
      ld.done_m = cq.done_tgl;
      ld.done_s = lq.done_m;
      ld.done_p = lq.done_s;
      ld.sda_lvl = 1'b0;
      if (done_evt) begin
         ld.adc  = cq.result; // [RULE15]
         ld.busy = 1'b0;
         if (lq.ctrl[`CTRL_AUTO_BIT]) begin
            ld.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO] = next_chan(
               lq.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO],
               lq.ctrl[`CTRL_CFG_HI:`CTRL_CFG_LO]); // [RULE6] [RULE7]
         end
      end
      if (start_evt) begin
         // Repeated start also ends a write
         ld.state   = ST_ADDR; // [RULE2] [RULE18]
         ld.bit_cnt = 4'h0;
         ld.sda_oe  = 1'b0;
      end else if (stop_evt) begin
         ld.state  = ST_IDLE; // [RULE18]
         ld.sda_oe = 1'b0;
      end else begin
         unique case (lq.state)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  ld.shift   = {lq.shift[6:0], lq.sda_s}; // [RULE19]
                  ld.bit_cnt = 4'(lq.bit_cnt + 4'h1);
               end else if (scl_fall && lq.bit_cnt == `BYTE_BITS) begin
                  if (addr_match) begin
                     ld.sda_oe = 1'b1; // [RULE22]
                     ld.rd     = lq.shift[0]; // [RULE2]
                     ld.state  = ST_ADDR_ACK;
                  end else begin
                     ld.state = ST_IDLE; // [RULE1]
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  ld.sda_oe   = 1'b0;
                  ld.bit_cnt  = 4'h0;
                  ld.got_ctrl = 1'b0;
                  ld.state    = ST_WR_BYTE;
                  load_rd     = lq.rd; // [RULE13]
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise) begin
                  ld.shift   = {lq.shift[6:0], lq.sda_s};
                  ld.bit_cnt = 4'(lq.bit_cnt + 4'h1);
               end else if (scl_fall && lq.bit_cnt == `BYTE_BITS) begin
                  ld.sda_oe = 1'b1; // [RULE22]
                  ld.state  = ST_WR_ACK;
                  if (!lq.got_ctrl) begin
                     wr_ctrl     = 1'b1;
                     ld.got_ctrl = 1'b1;
                     // Reserved bits kept as written
                     ld.ctrl = {lq.shift[7:2], clamp_chan(lq.shift[1:0],
                                lq.shift[5:4])}; // [RULE3] [RULE4] [RULE5]
                  end else begin
                     ld.dac = lq.shift; // [RULE10] [RULE11]
                  end
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  ld.sda_oe  = 1'b0;
                  ld.bit_cnt = 4'h0;
                  ld.state   = ST_WR_BYTE; // [RULE21]
               end
            end
            ST_RD_BYTE: begin
               if (scl_rise) begin
                  ld.bit_cnt = 4'(lq.bit_cnt + 4'h1);
               end else if (scl_fall) begin
                  if (lq.bit_cnt == `BYTE_BITS) begin
                     ld.sda_oe = 1'b0;
                     ld.state  = ST_RD_ACK;
                  end else begin
                     ld.shift  = {lq.shift[6:0], 1'b0};
                     ld.sda_oe = ~lq.shift[6]; // [RULE19]
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise && lq.sda_s) begin
                  ld.state = ST_IDLE; // [RULE23]
               end else if (scl_fall) begin
                  load_rd = 1'b1; // [RULE13] [RULE21]
               end
            end
         endcase
      end
      if (load_rd) begin
         ld.shift   = rd_value; // [RULE15] [RULE16]
         ld.sda_oe  = ~rd_value[7];
         ld.bit_cnt = 4'h0;
         ld.state   = ST_RD_BYTE;
         // A request still running is not restarted
         if (!lq.busy || done_evt) begin
            ld.busy = 1'b1;
            ld.req.chan   = ld.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO];
            ld.req.in_cfg = ld.ctrl[`CTRL_CFG_HI:`CTRL_CFG_LO];
            ld.req.diff   = is_diff(ld.req.chan, ld.req.in_cfg); // [RULE14]
            ld.req_tgl    = ~lq.req_tgl; // [RULE13]
         end
      end
      // Oscillator only runs while something needs it
      ld.osc_en    = lq.ctrl[`CTRL_OUT_EN_BIT] | lq.busy; // [RULE9]
      ld.osc_oe    = lq.osc_en & ~lq.srcsel_s; // [RULE17]
      ld.outbuf_en = lq.ctrl[`CTRL_OUT_EN_BIT]; // [RULE11]
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         lq <= '{state: ST_IDLE, ctrl: `CTRL_RESET, dac: `DAC_RESET,
                 adc: `ADC_RESET, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                 sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                 default: '0}; // [RULE9] [RULE16]
      end else begin
         lq <= ld;
      end
   end

   // Conversion side on the oscillator clock
   always_comb begin
      cd = cq;
      cd.req_m  = lq.req_tgl;
      cd.req_s  = cq.req_m;
      cd.req_p  = cq.req_s;
      cd.sample = 1'b0;
      if (!cq.busy) begin
         if (cq.req_s != cq.req_p) begin
            cd.req    = lq.req;
            cd.busy   = 1'b1; // [RULE12]
            cd.step   = `SAR_TOP;
            cd.code   = `SAR_FIRST_CODE;
            cd.sample = 1'b1; // [RULE14]
         end
      end else begin
         cd.code[cq.step] = comparator_in;
         if (cq.step != 3'h0) begin
            cd.code[3'(cq.step - 3'h1)] = 1'b1;
            cd.step = 3'(cq.step - 3'h1);
         end else begin
            cd.busy = 1'b0;
            // Offset binary to two's complement for differential pairs
            cd.result = {cd.code[7] ^ (cq.req.diff & `DIFF_FLIP),
                         cd.code[6:0]}; // [RULE14]
            cd.done_tgl = ~cq.done_tgl;
         end
      end
   end

   always_ff @(posedge conv_clk_in or negedge conv_rst_n) begin
      if (!conv_rst_n) begin
         cq <= '{result: `ADC_RESET, default: '0};
      end else begin
         cq <= cd;
      end
   end

   assign sda_out          = lq.sda_lvl;
   assign sda_oe_out       = lq.sda_oe;
   assign osc_enable_out   = lq.osc_en;
   assign osc_pin_oe_out   = lq.osc_oe;
   assign outbuf_enable_out = lq.outbuf_en;
   assign dac_value_out    = lq.dac;
   assign sar_code_out     = cq.code;
   assign track_hold_out   = cq.busy; // [RULE12]
   assign adc_sample_out   = cq.sample;
   assign mux_channel_out  = cq.req.chan;
   assign input_config_out = cq.req.in_cfg;
   assign differential_out = cq.req.diff;

   a_foreign_ignored: assert property ( // [RULE1]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (lq.state == ST_ADDR && scl_fall && lq.bit_cnt == `BYTE_BITS &&
       !addr_match && !start_evt && !stop_evt)
      |=> (lq.state == ST_IDLE && !lq.sda_oe))
      else $error("foreign address acknowledged");
   a_own_addr_ack: assert property ( // [RULE22]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (lq.state == ST_ADDR && scl_fall && lq.bit_cnt == `BYTE_BITS &&
       addr_match && !start_evt && !stop_evt)
      |=> lq.sda_oe && lq.rd == $past(lq.shift[0]))
      else $error("own address not acknowledged");
   a_ctrl_write: assert property ( // [RULE3]
      @(posedge ref_clk_in) disable iff (!rst_n)
      wr_ctrl |=> lq.ctrl[7:2] == $past(lq.shift[7:2]) &&
                  lq.got_ctrl && lq.sda_oe)
      else $error("control byte not stored");
   a_chan_range: assert property ( // [RULE7]
      @(posedge ref_clk_in) disable iff (!rst_n)
      lq.ctrl[`CTRL_CHAN_HI:`CTRL_CHAN_LO] <=
         max_chan(lq.ctrl[`CTRL_CFG_HI:`CTRL_CFG_LO]))
      else $error("channel beyond configuration");
   a_auto_step: assert property ( // [RULE6]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (done_evt && lq.ctrl[`CTRL_AUTO_BIT] && !wr_ctrl)
      |=> lq.ctrl[1:0] == next_chan($past(lq.ctrl[1:0]),
                                    $past(lq.ctrl[5:4])))
      else $error("channel not advanced");
   a_dac_write: assert property ( // [RULE10]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (lq.state == ST_WR_BYTE && lq.got_ctrl && scl_fall &&
       lq.bit_cnt == `BYTE_BITS && !start_evt && !stop_evt)
      |=> lq.dac == $past(lq.shift) ##1 dac_value_out == $past(lq.shift, 2))
      else $error("output value not stored");
   a_read_start: assert property ( // [RULE13]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (load_rd && !lq.busy)
      |=> lq.req_tgl != $past(lq.req_tgl) && lq.busy &&
          lq.sda_oe == !$past(rd_value[7]))
      else $error("read did not start conversion");
   a_nack_release: assert property ( // [RULE23]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (lq.state == ST_RD_ACK && scl_rise && lq.sda_s &&
       !start_evt && !stop_evt)
      |=> (lq.state == ST_IDLE && !lq.sda_oe) [*2])
      else $error("data line kept after nack");
   a_oe_on_low: assert property ( // [RULE19]
      @(posedge ref_clk_in) disable iff (!rst_n)
      (!scl_fall && !start_evt && !stop_evt) |=> $stable(lq.sda_oe))
      else $error("data changed outside clock low");
   a_hold_span: assert property ( // [RULE12]
      @(posedge conv_clk_in) disable iff (!conv_rst_n)
      (cq.req_s != cq.req_p && !cq.busy)
      |=> track_hold_out [*8] ##1
          (!track_hold_out && cq.done_tgl != $past(cq.done_tgl)))
      else $error("conversion length wrong");
   a_code_form: assert property ( // [RULE14]
      @(posedge conv_clk_in) disable iff (!conv_rst_n)
      (cq.busy && cq.step == 3'h0)
      |=> cq.result[6:1] == $past(cq.code[6:1]) &&
          cq.result[7] == ($past(cq.code[7]) ^ $past(cq.req.diff)))
      else $error("result coding wrong");
   c_ctrl_write: cover property (
      @(posedge ref_clk_in) disable iff (!rst_n) wr_ctrl);
   c_dac_write: cover property (
      @(posedge ref_clk_in) disable iff (!rst_n)
      lq.state == ST_WR_ACK && lq.got_ctrl && $changed(lq.dac));
   c_read_done: cover property (
      @(posedge ref_clk_in) disable iff (!rst_n) load_rd ##[1:900] done_evt);
   c_read_nack: cover property (
      @(posedge ref_clk_in) disable iff (!rst_n)
      lq.state == ST_RD_ACK && scl_rise && lq.sda_s);

endmodule // conv_ctrl

// file: rtl/conv_ctrl_regs.svh
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH

// Control register fields
`define CTRL_OUT_EN_BIT 6
`define CTRL_CFG_HI     5
`define CTRL_CFG_LO     4
`define CTRL_AUTO_BIT   2
`define CTRL_CHAN_HI    1
`define CTRL_CHAN_LO    0

// Reset values
`define CTRL_RESET      8'h00
`define DAC_RESET       8'h00
`define ADC_RESET       8'h80

// Serial byte framing
`define BYTE_BITS       4'h8
`define ADDR_TYPE_DEF   4'h9

// Successive approximation
`define SAR_TOP         3'h7
`define SAR_FIRST_CODE  8'h80
`define DIFF_FLIP       1'h1

`endif

// file: rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK
   } bus_state_t;

   typedef struct packed {
      logic [1:0] chan;
      logic [1:0] in_cfg;
      logic       diff;
   } conv_req_t;

   typedef struct packed {
      logic       scl_m;
      logic       scl_s;
      logic       scl_p;
      logic       sda_m;
      logic       sda_s;
      logic       sda_p;
      logic [2:0] addr_m;
      logic [2:0] addr_s;
      logic       srcsel_m;
      logic       srcsel_s;
      logic       done_m;
      logic       done_s;
      logic       done_p;
      bus_state_t state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic       rd;
      logic       got_ctrl;
      logic       sda_oe;
      logic       sda_lvl;
      logic [7:0] ctrl;
      logic [7:0] dac;
      logic [7:0] adc;
      conv_req_t  req;
      logic       req_tgl;
      logic       busy;
      logic       osc_en;
      logic       osc_oe;
      logic       outbuf_en;
   } link_state_t;

   typedef struct packed {
      logic       req_m;
      logic       req_s;
      logic       req_p;
      conv_req_t  req;
      logic       busy;
      logic [2:0] step;
      logic [7:0] code;
      logic [7:0] result;
      logic       done_tgl;
      logic       sample;
   } sar_state_t;

endpackage

// file: verif/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model #(
   parameter int QUARTER = 30
) (
   input  wire logic ref_clk_in,
   input  wire logic sda_bus_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // Bus idles with both lines released
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic wait_q();
      repeat (QUARTER) @(posedge ref_clk_in);
   endtask

   // Also serves as repeated start when entered with the clock low
   task automatic start_cond();
      sda_low_out <= 1'b0;
      wait_q();
      scl_out <= 1'b1;
      wait_q();
      sda_low_out <= 1'b1;
      wait_q();
      scl_out <= 1'b0;
      wait_q();
   endtask

   task automatic stop_cond();
      sda_low_out <= 1'b1;
      wait_q();
      scl_out <= 1'b1;
      wait_q();
      sda_low_out <= 1'b0;
      wait_q();
   endtask

   // Data moves only while the clock is low
   task automatic xfer_bit(input logic drive, output logic seen);
      sda_low_out <= ~drive;
      wait_q();
      scl_out <= 1'b1;
      wait_q();
      seen = sda_bus_in;
      wait_q();
      scl_out <= 1'b0;
      wait_q();
   endtask

   task automatic send_byte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(b[i], s);
      end
      xfer_bit(1'b1, s);
      acked = ~s;
   endtask

   // Leaving the last byte unacknowledged ends the read
   task automatic recv_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, b[i]);
      end
      xfer_bit(~ack, s);
   endtask
endmodule // i2c_master_model

// file: verif/conv_ctrl_tb_top.sv
`timescale 1ns/1ns
module conv_ctrl_tb_top;
   localparam logic [3:0] TYPE   = 4'h9;
   localparam logic [2:0] PINS   = 3'b101;
   localparam logic [7:0] ADDR_W = {TYPE, PINS, 1'b0};
   localparam logic [7:0] ADDR_R = {TYPE, PINS, 1'b1};

   logic       ref_clk = 1'b0;
   logic       conv_clk = 1'b0;
   logic       resetn = 1'b0;
   logic [2:0] pins = PINS;
   logic       clk_src_sel = 1'b0;
   logic       scl;
   logic       master_low;
   logic       sda_o;
   logic       sda_oe;
   logic       sda_bus;
   logic       osc_en;
   logic       osc_pin_oe;
   logic       outbuf_en;
   logic [7:0] dac_value;
   logic [7:0] sar_code;
   logic       track_hold;
   logic       adc_sample;
   logic [1:0] mux_chan;
   logic [1:0] in_cfg;
   logic       diff;
   logic       comparator;
   logic [7:0] level [4];
   logic       seen_hold = 1'b0;
   logic       seen_sample = 1'b0;
   logic       ack;
   logic [7:0] rd;
   int         num_errors;
   int         samples_checked;

   always #20 ref_clk = ~ref_clk;
   initial begin
      #3;
      forever #6 conv_clk = ~conv_clk;
   end

   // Open drain with pull-up
   assign sda_bus = (sda_oe ? sda_o : 1'b1) & ~master_low;
   // Input sits half a step above its code, so above equals at-or-above
   assign comparator = ({level[mux_chan], 1'b1} > {sar_code, 1'b0});

   always @(posedge conv_clk) begin
      if (track_hold) seen_hold <= 1'b1;
      if (adc_sample) seen_sample <= 1'b1;
   end

   conv_ctrl #(.ADDR_TYPE(TYPE)) u_conv_ctrl (
      .ref_clk_in                 (ref_clk),
      .resetn_in                  (resetn),
      .conv_clk_in                (conv_clk),
      .scl_in                     (scl),
      .sda_in                     (sda_bus),
      .addr_select_pin_0_in       (pins[0]),
      .addr_select_pin_1_in       (pins[1]),
      .addr_select_pin_2_in       (pins[2]),
      .clock_source_select_pin_in (clk_src_sel),
      .comparator_in              (comparator),
      .sda_out                    (sda_o),
      .sda_oe_out                 (sda_oe),
      .osc_enable_out             (osc_en),
      .osc_pin_oe_out             (osc_pin_oe),
      .outbuf_enable_out          (outbuf_en),
      .dac_value_out              (dac_value),
      .sar_code_out               (sar_code),
      .track_hold_out             (track_hold),
      .adc_sample_out             (adc_sample),
      .mux_channel_out            (mux_chan),
      .input_config_out           (in_cfg),
      .differential_out           (diff)
   );

   i2c_master_model u_i2c_master_model (
      .ref_clk_in  (ref_clk),
      .sda_bus_in  (sda_bus),
      .scl_out     (scl),
      .sda_low_out (master_low)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic wr(input logic [7:0] b);
      u_i2c_master_model.send_byte(b, ack);
      check({7'h00, ack}, 8'h01);
   endtask

   task automatic tally_and_finish();
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge ref_clk);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] bad [2];
      num_errors = 0;
      samples_checked = 0;
      level[0] = 8'h3C;
      level[1] = 8'hA5;
      level[2] = 8'h81;
      level[3] = 8'hFF;
      bad[0] = {TYPE, 3'b100, 1'b0};
      bad[1] = {4'h8, PINS, 1'b0};
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (5) @(posedge ref_clk);
      check({outbuf_en, osc_en, sda_oe, 5'h00}, 8'h00);
      // Foreign addresses get no acknowledge
      for (int i = 0; i < 2; i++) begin
         u_i2c_master_model.start_cond();
         u_i2c_master_model.send_byte(bad[i], ack);
         check({7'h00, ack}, 8'h00);
         u_i2c_master_model.stop_cond();
      end
      // Control, then two output values back to back
      u_i2c_master_model.start_cond();
      wr(ADDR_W);
      wr(8'h44);
      wr(8'hA7);
      wr(8'h5C);
      u_i2c_master_model.stop_cond();
      check(dac_value, 8'h5C);
      check({7'h00, outbuf_en}, 8'h01);
      check({7'h00, osc_pin_oe}, 8'h01);
      clk_src_sel <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check({7'h00, osc_pin_oe}, 8'h00);
      clk_src_sel <= 1'b0;
      // Read with auto-increment across the wrap
      u_i2c_master_model.start_cond();
      wr(ADDR_R);
      u_i2c_master_model.recv_byte(1'b1, rd);
      check(rd, 8'h80);
      for (int i = 0; i < 5; i++) begin
         u_i2c_master_model.recv_byte(i < 4, rd);
         check(rd, level[i % 4]);
      end
      repeat (8) @(posedge ref_clk);
      check({7'h00, sda_oe}, 8'h00);
      u_i2c_master_model.stop_cond();
      check({6'h00, seen_hold, seen_sample}, 8'h03);
      check(dac_value, 8'h5C);
      // Differential, out-of-range channel, write ended by Sr
      u_i2c_master_model.start_cond();
      wr(ADDR_W);
      wr(8'h13);
      u_i2c_master_model.start_cond();
      wr(ADDR_R);
      u_i2c_master_model.recv_byte(1'b1, rd);
      check(rd, level[1]);
      u_i2c_master_model.recv_byte(1'b0, rd);
      check(rd, level[2] ^ 8'h80);
      check({3'h0, mux_chan, in_cfg, diff}, 8'h13);
      u_i2c_master_model.stop_cond();
      check({7'h00, outbuf_en}, 8'h00);
      tally_and_finish();
   end
endmodule // conv_ctrl_tb_top
